//--- dcc_chan_if.sv
// Purpose: carrier between the bank and one channel's conduction logic
// Assumes: one instance per channel, same clock as the bank
// Notes: bank drives writes and channel state, channel returns its register
`timescale 1ns/100ps
`default_nettype none
interface dcc_chan_if;
   import dcc_pkg::*;
   logic wr_stb; // one-cycle write of conduction mode
   dcc_byte_type wr_data; // written byte
   logic soft_rst; // return to defaults
   logic chan_on; // channel running
   logic ramp_up; // ramping on
   logic ramp_down; // ramping off
   dcc_byte_type mode; // stored register value
   logic vrange_refused; // range change refused pulse
   logic ilimit_high; // high current range
   logic servo_active; // servo allowed now
   logic vrange_low; // low voltage range
   logic continuous; // effective conduction mode
   modport bank (output wr_stb, wr_data, soft_rst, chan_on, ramp_up, ramp_down,
      input mode, vrange_refused, ilimit_high, servo_active, vrange_low, continuous);
   modport chan (input wr_stb, wr_data, soft_rst, chan_on, ramp_up, ramp_down,
      output mode, vrange_refused, ilimit_high, servo_active, vrange_low, continuous);
endinterface : dcc_chan_if
`default_nettype wire

//--- dcc_channel.sv
// Purpose: conduction mode register and its effects for one channel
// Assumes: writes arrive as single-cycle strobes from the bank
// Notes: outputs other than the refusal pulse are registered from the next value and change on the same edge as the stored value
`timescale 1ns/100ps
`default_nettype none
module dcc_channel
   import dcc_pkg::*;
(
   input wire logic clk_in, // 25 MHz clock
   input wire logic rst_n_in, // async reset, active low
   dcc_chan_if.chan bus // bank side
);
   logic vrange_change;
   logic vrange_locked;
   dcc_byte_type masked_data;
   dcc_byte_type next_mode;

   // reserved bits forced to zero, range bit held while running
   assign masked_data = bus.wr_data & DCC_CM_WRITABLE_MASK;
   assign vrange_change = masked_data[DCC_CM_VRANGE_LOW_BIT] != bus.mode[DCC_CM_VRANGE_LOW_BIT];
   assign vrange_locked = bus.chan_on && vrange_change;
   always_comb
   begin
      next_mode = bus.mode;
      if (bus.soft_rst)
      begin
         next_mode = DCC_CONDUCTION_MODE_RESET;
      end
      else if (bus.wr_stb)
      begin
         next_mode = masked_data;
         if (vrange_locked)
         begin
            next_mode[DCC_CM_VRANGE_LOW_BIT] = bus.mode[DCC_CM_VRANGE_LOW_BIT];
         end
      end
   end

   // register and derived controls
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bus.mode <= DCC_CONDUCTION_MODE_RESET;
         bus.vrange_refused <= 1'b0;
         bus.ilimit_high <= 1'b0;
         bus.servo_active <= 1'b0;
         bus.vrange_low <= 1'b0;
         bus.continuous <= 1'b0;
      end
      else
      begin
         bus.mode <= next_mode;
         bus.vrange_refused <= bus.wr_stb && !bus.soft_rst && vrange_locked;
         bus.ilimit_high <= next_mode[DCC_CM_ILIMIT_HIGH_BIT];
         // servo only in steady on state
         bus.servo_active <= next_mode[DCC_CM_SERVO_BIT] && bus.chan_on
            && !bus.ramp_up && !bus.ramp_down;
         bus.vrange_low <= next_mode[DCC_CM_VRANGE_LOW_BIT];
         // ramping on forces pulse skipping
         bus.continuous <= next_mode[DCC_CM_CONTINUOUS_BIT] && !bus.ramp_up;
      end
   end
endmodule : dcc_channel
`default_nettype wire

//--- dcc_checker.sv
// Purpose: timing and register checks on the bank's top ports
// Assumes: run pins reach the bank through a two flop synchroniser
// Notes: running is judged only after the run pins stood still three edges
`timescale 1ns/100ps
`default_nettype none
module dcc_checker
   import dcc_pkg::*;
(
   input wire logic clk_in, // bank clock
   input wire logic rst_n_in, // async reset
   input wire logic cmd_wr_in, // write strobe
   input wire logic cmd_rd_in, // read strobe
   input wire logic [7:0] cmd_code_in, // command code
   input wire logic [15:0] wr_data_in, // write data
   input wire logic [1:0] run_pin_in, // run pins
   input wire logic [1:0] cmd_on_in, // commanded on
   input wire logic [1:0] ramp_up_in, // ramping on
   input wire logic [15:0] rd_data_out, // read data
   input wire logic rd_valid_out, // read valid
   input wire logic busy_fault_out, // busy pulse
   input wire logic busy_flag_out, // sticky busy
   input wire logic soft_reset_out, // soft reset pulse
   input wire logic [1:0] continuous_out, // continuous mode
   input wire logic [1:0] servo_active_out, // servo running
   input wire logic [15:0] switching_rate_out // rate word
);
   logic [5:0] run_hist;
   logic run_steady;
   logic run_idle;
   // run pin history over three edges
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         run_hist <= 6'h00;
      else
         run_hist <= {run_hist[3:0], run_pin_in};
   end
   // running or idle as the bank must see it
   assign run_steady = (run_hist == {3{run_pin_in}}) && (|(run_pin_in & cmd_on_in));
   assign run_idle = (run_hist == 6'h00) && (run_pin_in == 2'h0);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_soft_wr;
      cmd_wr_in && (cmd_code_in == DCC_CMD_SOFT_RESET);
   endsequence
   sequence s_rate_wr;
      cmd_wr_in && (cmd_code_in == DCC_CMD_SWITCHING_RATE);
   endsequence
   sequence s_phase_wr;
      cmd_wr_in && (cmd_code_in == DCC_CMD_PHASE_COUPLING);
   endsequence
   chk_soft_pulse: assert property (s_soft_wr |=> soft_reset_out)
      else $error("soft reset pulse missing");
   chk_soft_defaults: assert property (s_soft_wr
      |-> ##2 (switching_rate_out == DCC_SWITCHING_RATE_RESET))
      else $error("rate word not back to default after soft reset");
   chk_read_answer: assert property (cmd_rd_in && (cmd_code_in == DCC_CMD_PHASE_COUPLING)
      |=> rd_valid_out && ((rd_data_out & 16'hFF68) == 16'h0000))
      else $error("phase read answer wrong");
   chk_rate_busy: assert property (s_rate_wr ##0 run_steady
      |=> busy_fault_out ##1 $stable(switching_rate_out))
      else $error("rate write while running not refused");
   chk_rate_accept: assert property (s_rate_wr ##0 run_idle
      |-> ##2 (switching_rate_out == $past(wr_data_in, 2)))
      else $error("rate write while off not taken");
   chk_phase_busy: assert property (s_phase_wr ##0 run_steady
      |=> busy_fault_out && busy_flag_out)
      else $error("phase write while running not refused");
   chk_ramp_dcm: assert property (ramp_up_in[0] |=> !continuous_out[0])
      else $error("continuous mode during ramp on");
   chk_servo_off: assert property (!cmd_on_in[0] |=> !servo_active_out[0])
      else $error("servo active while channel off");
   chk_busy_sticky: assert property (busy_fault_out |-> busy_flag_out)
      else $error("busy pulse without sticky flag");
endmodule : dcc_checker
bind dcc_top dcc_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_wr_in(cmd_wr_in),
   .cmd_rd_in(cmd_rd_in), .cmd_code_in(cmd_code_in), .wr_data_in(wr_data_in),
   .run_pin_in(run_pin_in), .cmd_on_in(cmd_on_in), .ramp_up_in(ramp_up_in),
   .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .busy_fault_out(busy_fault_out),
   .busy_flag_out(busy_flag_out), .soft_reset_out(soft_reset_out),
   .continuous_out(continuous_out), .servo_active_out(servo_active_out),
   .switching_rate_out(switching_rate_out));
`default_nettype wire

//--- dcc_host_model.sv
// Purpose: host model issuing configuration commands to the bank
// Assumes: one strobe per command, answer sampled just after the taking edge
// Notes: code and data lines carry inverted junk once released
`timescale 1ns/100ps
`default_nettype none
module dcc_host_model
(
   input wire logic clk_in, // bank clock
   output logic cmd_wr_out, // write strobe
   output logic cmd_rd_out, // read strobe
   output logic [7:0] cmd_code_out, // command code
   output logic [7:0] page_out, // page
   output logic [15:0] wr_data_out, // write data
   input wire logic [15:0] rd_data_in, // read data
   input wire logic rd_valid_in // read answer
);
   // idle lines at time zero
   initial
   begin
      cmd_wr_out = 1'b0;
      cmd_rd_out = 1'b0;
      cmd_code_out = 8'h00;
      page_out = 8'h00;
      wr_data_out = 16'h0000;
   end
   // hold the request through its taking edge, release on it, take the answer
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] page,
      input logic [15:0] data, output logic [16:0] ans);
      cmd_wr_out = wr;
      cmd_rd_out = !wr;
      cmd_code_out = code;
      page_out = page;
      wr_data_out = data;
      @(posedge clk_in);
      cmd_wr_out <= 1'b0;
      cmd_rd_out <= 1'b0;
      cmd_code_out <= ~code;
      wr_data_out <= ~data;
      #1;
      ans = {rd_valid_in, rd_data_in};
   endtask : xfer
endmodule : dcc_host_model
`default_nettype wire

//--- dcc_pkg.sv
// Purpose: shared constants for the dual channel conversion configuration bank
// Assumes: command codes arrive already decoded from the management bus framer
// Notes: values after reset equal the stored power-on defaults of each register
`default_nettype none
package dcc_pkg;
   // command codes
   localparam logic [7:0] DCC_CMD_SWITCHING_RATE = 8'h33;
   localparam logic [7:0] DCC_CMD_CONDUCTION_MODE = 8'hD4;
   localparam logic [7:0] DCC_CMD_PHASE_COUPLING = 8'hF5;
   localparam logic [7:0] DCC_CMD_SOFT_RESET = 8'hFD;
   localparam logic [7:0] DCC_PAGE_ALL = 8'hFF;
   // values after reset
   localparam logic [15:0] DCC_SWITCHING_RATE_RESET = 16'hFABC;
   localparam logic [7:0] DCC_CONDUCTION_MODE_RESET = 8'hC1;
   localparam logic [7:0] DCC_PHASE_COUPLING_RESET = 8'h10;
   // conduction mode fields
   localparam int DCC_CM_ILIMIT_HIGH_BIT = 7;
   localparam int DCC_CM_SERVO_BIT = 6;
   localparam int DCC_CM_VRANGE_LOW_BIT = 1;
   localparam int DCC_CM_CONTINUOUS_BIT = 0;
   localparam logic [7:0] DCC_CM_WRITABLE_MASK = 8'hC3;
   // phase and coupling fields
   localparam int DCC_PC_COUPLE_BIT = 7;
   localparam int DCC_PC_SHARE_CLK_BIT = 4;
   localparam int DCC_PC_PHASE_LSB = 0;
   localparam int DCC_PC_PHASE_W = 3;
   localparam logic [7:0] DCC_PC_WRITABLE_MASK = 8'h97;
   localparam logic [2:0] DCC_PHASE_CODE_MAX = 3'h6;
   // phase offsets in degrees, channel 0 then channel 1, per code
   localparam int DCC_PHASE_COUNT = 7;
   localparam logic [8:0] DCC_PHASE_CH0_DEG [DCC_PHASE_COUNT] = '{
      9'h000, 9'h05A, 9'h000, 9'h000, 9'h078, 9'h03C, 9'h078};
   localparam logic [8:0] DCC_PHASE_CH1_DEG [DCC_PHASE_COUNT] = '{
      9'h0B4, 9'h10E, 9'h0F0, 9'h078, 9'h0F0, 9'h0F0, 9'h12C};
   // synchroniser depth
   localparam int DCC_SYNC_STAGES = 2;
   typedef logic [7:0] dcc_byte_type;
   typedef enum logic [1:0] {DCC_RD_NONE, DCC_RD_DATA, DCC_RD_REFUSED} dcc_rd_type;
endpackage : dcc_pkg
`default_nettype wire

//--- dcc_top.sv
// Purpose: configuration bank for a two channel step-down controller
// Assumes: a bus framer hands over decoded command, page and data, one strobe each
// Notes: run pins and input voltage comparators are asynchronous and are synchronised
`timescale 1ns/100ps
`default_nettype none
module dcc_top
   import dcc_pkg::*;
(
   input wire logic clk_in, // 25 MHz clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic cmd_wr_in, // write command strobe
   input wire logic cmd_rd_in, // read command strobe
   input wire logic [7:0] cmd_code_in, // command code
   input wire logic [7:0] page_in, // current page, 0xFF for all
   input wire logic [15:0] wr_data_in, // write data, bytes in low lane
   input wire logic clear_faults_in, // clears the sticky busy flag
   input wire logic [1:0] run_pin_in, // run pins, asynchronous
   input wire logic [1:0] cmd_on_in, // channel commanded on
   input wire logic [1:0] ramp_up_in, // channel ramping on
   input wire logic [1:0] ramp_down_in, // channel ramping off
   input wire logic vin_above_on_in, // input above turn-on, asynchronous
   input wire logic vin_below_off_in, // input below turn-off, asynchronous
   input wire logic share_clk_in, // share clock pin level
   output logic [15:0] rd_data_out, // read data
   output logic rd_valid_out, // read data valid pulse
   output logic busy_fault_out, // busy fault event pulse
   output logic busy_flag_out, // sticky busy status
   output logic cml_fault_out, // unsupported command pulse
   output logic soft_reset_out, // soft reset pulse
   output logic [1:0] ilimit_high_out, // high current range per channel
   output logic [1:0] servo_active_out, // servo running per channel
   output logic [1:0] vrange_low_out, // low voltage range per channel
   output logic [1:0] continuous_out, // forced continuous per channel
   output logic [15:0] switching_rate_out, // switching rate word
   output logic [8:0] phase0_deg_out, // channel 0 phase degrees
   output logic [8:0] phase1_deg_out, // channel 1 phase degrees
   output logic ea_coupled_out, // amplifiers coupled
   output logic share_clk_out, // share clock drive level
   output logic share_clk_oe_n_out, // share clock enable, low drives
   output logic share_clk_level_out // synchronised pin level
);
   // synchroniser stages
   logic [1:0] run_meta;
   logic [1:0] run_sync;
   logic [1:0] vin_meta;
   logic [1:0] vin_sync;
   logic share_meta;
   logic share_sync;
   // stored registers
   logic [15:0] switching_rate_setting;
   dcc_byte_type phase_and_coupling_config;
   // share clock state
   logic vin_ever_up;
   logic vin_released;
   logic share_pull;
   // decode
   logic [1:0] chan_on;
   logic device_running;
   logic hit_rate;
   logic hit_mode;
   logic hit_phase;
   logic hit_reset;
   logic known_cmd;
   logic [1:0] page_sel;
   logic page_valid;
   logic wr_rate;
   logic wr_phase;
   logic wr_reset;
   logic busy_rate;
   logic busy_phase;
   logic phase_bad;
   logic wr_bad;
   logic rd_bad;
   logic [1:0] vrange_refused;
   logic busy_event;
   logic soft_rst;
   dcc_byte_type phase_masked;
   logic [2:0] phase_code;
   dcc_byte_type mode_rd;
   dcc_rd_type rd_kind;
   logic [15:0] next_rd_data;
   logic [8:0] next_phase0;
   logic [8:0] next_phase1;

   dcc_chan_if chan_bus [2] ();

   // two-stage synchronisers for asynchronous inputs
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         run_meta <= 2'h0;
         run_sync <= 2'h0;
         vin_meta <= 2'h0;
         vin_sync <= 2'h0;
         share_meta <= 1'b0;
         share_sync <= 1'b0;
      end
      else
      begin
         run_meta <= run_pin_in;
         run_sync <= run_meta;
         vin_meta <= {vin_below_off_in, vin_above_on_in};
         vin_sync <= vin_meta;
         share_meta <= share_clk_in;
         share_sync <= share_meta;
      end
   end

   // running means run pin high and commanded on
   assign chan_on = run_sync & cmd_on_in;
   assign device_running = |chan_on;

   // command decode
   assign hit_rate = cmd_code_in == DCC_CMD_SWITCHING_RATE;
   assign hit_mode = cmd_code_in == DCC_CMD_CONDUCTION_MODE;
   assign hit_phase = cmd_code_in == DCC_CMD_PHASE_COUPLING;
   assign hit_reset = cmd_code_in == DCC_CMD_SOFT_RESET;
   assign known_cmd = hit_rate || hit_mode || hit_phase || hit_reset;
   assign page_valid = (page_in == 8'h00) || (page_in == 8'h01) || (page_in == DCC_PAGE_ALL);
   assign page_sel[0] = (page_in == 8'h00) || (page_in == DCC_PAGE_ALL);
   assign page_sel[1] = (page_in == 8'h01) || (page_in == DCC_PAGE_ALL);

   // phase write validation, reserved bits dropped
   assign phase_masked = wr_data_in[7:0] & DCC_PC_WRITABLE_MASK;
   assign phase_code = phase_masked[DCC_PC_PHASE_LSB +: DCC_PC_PHASE_W];
   assign phase_bad = phase_code > DCC_PHASE_CODE_MAX;

   // accepted writes and refusals
   assign wr_reset = cmd_wr_in && hit_reset;
   assign busy_rate = cmd_wr_in && hit_rate && device_running;
   assign busy_phase = cmd_wr_in && hit_phase && device_running;
   assign wr_rate = cmd_wr_in && hit_rate && !device_running;
   assign wr_phase = cmd_wr_in && hit_phase && !device_running && !phase_bad;
   assign wr_bad = cmd_wr_in && (!known_cmd || (hit_mode && !page_valid)
      || (hit_phase && !device_running && phase_bad));
   assign rd_bad = cmd_rd_in && (!known_cmd || hit_reset || (hit_mode && !page_valid));
   assign busy_event = busy_rate || busy_phase || (|vrange_refused);
   assign soft_rst = wr_reset;

   // per-channel conduction logic
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_chan
         assign chan_bus[g].wr_stb = cmd_wr_in && hit_mode && page_sel[g];
         assign chan_bus[g].wr_data = wr_data_in[7:0];
         assign chan_bus[g].soft_rst = soft_rst;
         assign chan_bus[g].chan_on = chan_on[g];
         assign chan_bus[g].ramp_up = ramp_up_in[g];
         assign chan_bus[g].ramp_down = ramp_down_in[g];
         assign vrange_refused[g] = chan_bus[g].vrange_refused;
         assign ilimit_high_out[g] = chan_bus[g].ilimit_high;
         assign servo_active_out[g] = chan_bus[g].servo_active;
         assign vrange_low_out[g] = chan_bus[g].vrange_low;
         assign continuous_out[g] = chan_bus[g].continuous;
         dcc_channel u_chan (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .bus(chan_bus[g].chan)
         );
      end
   endgenerate

   // paged read picks channel 1 only when page 1 is selected
   assign mode_rd = (page_in == 8'h01) ? chan_bus[1].mode : chan_bus[0].mode;

   // read answer selection
   always_comb
   begin
      next_rd_data = 16'h0000;
      rd_kind = DCC_RD_NONE;
      if (cmd_rd_in)
      begin
         rd_kind = rd_bad ? DCC_RD_REFUSED : DCC_RD_DATA;
         if (hit_rate)
         begin
            next_rd_data = switching_rate_setting;
         end
         else if (hit_mode && page_valid)
         begin
            next_rd_data = {8'h00, mode_rd};
         end
         else if (hit_phase)
         begin
            next_rd_data = {8'h00, phase_and_coupling_config};
         end
      end
   end

   // phase offset lookup
   assign next_phase0 = DCC_PHASE_CH0_DEG[phase_and_coupling_config[DCC_PC_PHASE_LSB +:
      DCC_PC_PHASE_W]];
   assign next_phase1 = DCC_PHASE_CH1_DEG[phase_and_coupling_config[DCC_PC_PHASE_LSB +:
      DCC_PC_PHASE_W]];

   // shared registers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         switching_rate_setting <= DCC_SWITCHING_RATE_RESET;
         phase_and_coupling_config <= DCC_PHASE_COUPLING_RESET;
      end
      else if (soft_rst)
      begin
         switching_rate_setting <= DCC_SWITCHING_RATE_RESET;
         phase_and_coupling_config <= DCC_PHASE_COUPLING_RESET;
      end
      else
      begin
         if (wr_rate)
         begin
            switching_rate_setting <= wr_data_in;
         end
         if (wr_phase)
         begin
            phase_and_coupling_config <= phase_masked;
         end
      end
   end

   // input voltage tracking for the share clock pin
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         vin_ever_up <= 1'b0;
         vin_released <= 1'b0;
      end
      else
      begin
         if (vin_sync[0])
         begin
            vin_ever_up <= 1'b1;
         end
         if (vin_sync[0])
         begin
            vin_released <= 1'b1;
         end
         else if (vin_sync[1])
         begin
            vin_released <= 1'b0;
         end
      end
   end

   // pull low decision depends on the share clock enable bit
   assign share_pull = phase_and_coupling_config[DCC_PC_SHARE_CLK_BIT]
      ? !vin_released
      : !vin_ever_up;

   // outputs and event flags
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_out <= 16'h0000;
         rd_valid_out <= 1'b0;
         busy_fault_out <= 1'b0;
         busy_flag_out <= 1'b0;
         cml_fault_out <= 1'b0;
         soft_reset_out <= 1'b0;
         switching_rate_out <= DCC_SWITCHING_RATE_RESET;
         phase0_deg_out <= 9'h000;
         phase1_deg_out <= 9'h000;
         ea_coupled_out <= 1'b0;
         share_clk_oe_n_out <= 1'b0;
         share_clk_level_out <= 1'b0;
      end
      else
      begin
         rd_data_out <= next_rd_data;
         rd_valid_out <= rd_kind == DCC_RD_DATA;
         busy_fault_out <= busy_event;
         // a new busy event wins over a clear in the same cycle
         if (busy_event)
         begin
            busy_flag_out <= 1'b1;
         end
         else if (clear_faults_in || soft_rst)
         begin
            busy_flag_out <= 1'b0;
         end
         cml_fault_out <= wr_bad || (rd_kind == DCC_RD_REFUSED);
         soft_reset_out <= soft_rst;
         switching_rate_out <= switching_rate_setting;
         phase0_deg_out <= next_phase0;
         phase1_deg_out <= next_phase1;
         ea_coupled_out <= phase_and_coupling_config[DCC_PC_COUPLE_BIT];
         share_clk_oe_n_out <= !share_pull;
         share_clk_level_out <= share_sync;
      end
   end

   // open drain pin only ever drives low
   assign share_clk_out = 1'b0;
endmodule : dcc_top
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the configuration bank
// Assumes: host model drives every command through its xfer task
// Notes: reference register values are kept in local variables
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import dcc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wr, rd, clr, input_turn_on_threshold, input_turn_off_threshold, sc_out, sc_oe_n, sc_lvl, sc_pin;
   logic rd_v, bsy, bsy_flag, cml, srst, coupled;
   logic [1:0] run, on, rup, rdn, ilim, servo, vrl, cont;
   logic [7:0] code, page, pg;
   logic [15:0] wdata, rdata, rate_o, pc, rate, d;
   logic [15:0] cm [2];
   logic [8:0] ph0, ph1;
   logic [16:0] ans;
   logic [8:0] tab0 [7] = '{9'h000, 9'h05A, 9'h000, 9'h000, 9'h078, 9'h03C, 9'h078};
   logic [8:0] tab1 [7] = '{9'h0B4, 9'h10E, 9'h0F0, 9'h078, 9'h0F0, 9'h0F0, 9'h12C};
   int error_cnt = 0;
   int num_checks = 0;
   int cycles = 0;
   int k;
   // clock and hang guard
   always #20 clk_in = ~clk_in;
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
   // open-drain share clock pin with pull-up
   assign sc_pin = sc_oe_n ? 1'b1 : sc_out;
   dcc_host_model host (.clk_in(clk_in), .cmd_wr_out(wr), .cmd_rd_out(rd), .cmd_code_out(code),
      .page_out(page), .wr_data_out(wdata), .rd_data_in(rdata), .rd_valid_in(rd_v));
   dcc_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_wr_in(wr), .cmd_rd_in(rd),
      .cmd_code_in(code), .page_in(page), .wr_data_in(wdata), .clear_faults_in(clr),
      .run_pin_in(run), .cmd_on_in(on), .ramp_up_in(rup), .ramp_down_in(rdn),
      .vin_above_on_in(input_turn_on_threshold), .vin_below_off_in(input_turn_off_threshold), .share_clk_in(sc_pin),
      .rd_data_out(rdata), .rd_valid_out(rd_v), .busy_fault_out(bsy), .busy_flag_out(bsy_flag),
      .cml_fault_out(cml), .soft_reset_out(srst), .ilimit_high_out(ilim),
      .servo_active_out(servo), .vrange_low_out(vrl), .continuous_out(cont),
      .switching_rate_out(rate_o), .phase0_deg_out(ph0), .phase1_deg_out(ph1),
      .ea_coupled_out(coupled), .share_clk_out(sc_out), .share_clk_oe_n_out(sc_oe_n),
      .share_clk_level_out(sc_lvl));
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cyc
   task automatic wrc(input logic [7:0] c, input logic [7:0] p, input logic [15:0] dt);
      host.xfer(1'b1, c, p, dt, ans);
   endtask : wrc
   task automatic rdc(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
      host.xfer(1'b0, c, p, 16'h0000, ans);
      chk(ans, {1'b1, e});
   endtask : rdc
   task automatic check_all();
      for (int i = 0; i < 2; i++)
      begin
         chk(ilim[i], cm[i][7]);
         chk(vrl[i], cm[i][1]);
         chk(cont[i], cm[i][0] & !rup[i]);
         chk(servo[i], cm[i][6] & run[i] & on[i] & !rup[i] & !rdn[i]);
      end
      chk(rate_o, rate);
      chk(ph0, tab0[pc[2:0]]);
      chk(ph1, tab1[pc[2:0]]);
      chk(coupled, pc[7]);
   endtask : check_all
   // main sequence
   initial
   begin
      {clr, input_turn_on_threshold, input_turn_off_threshold, run, on, rup, rdn} = 11'h000;
      cm[0] = 16'h00C1;
      cm[1] = 16'h00C1;
      pc = 16'h0010;
      rate = 16'hFABC;
      void'($urandom(26533));
      repeat (16) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      // derived outputs show defaults only after the first edge
      cyc(1);
      check_all();
      rdc(DCC_CMD_CONDUCTION_MODE, 8'h00, cm[0]);
      rdc(DCC_CMD_CONDUCTION_MODE, 8'h01, cm[1]);
      rdc(DCC_CMD_PHASE_COUPLING, 8'h00, pc);
      rdc(DCC_CMD_SWITCHING_RATE, 8'h00, rate);
      // every supported phase code (0 to 6) with random other bits, while off, board tied
      for (k = 0; k < 7; k++)
      begin
         d = 16'($urandom);
         d[2:0] = 3'(k);
         wrc(DCC_CMD_PHASE_COUPLING, 8'h00, d);
         pc = d & 16'h0097;
         cyc(1);
         check_all();
         rdc(DCC_CMD_PHASE_COUPLING, 8'h00, pc);
      end
      // random conduction bytes on each page, channels off
      for (k = 0; k < 6; k++)
      begin
         d = 16'($urandom);
         pg = (k % 3 == 2) ? 8'hFF : 8'(k % 3);
         wrc(DCC_CMD_CONDUCTION_MODE, pg, d);
         if (pg != 8'h01)
            cm[0] = d & 16'h00C3;
         if (pg != 8'h00)
            cm[1] = d & 16'h00C3;
         check_all();
         rdc(DCC_CMD_CONDUCTION_MODE, pg, cm[pg == 8'h01]);
      end
      wrc(DCC_CMD_CONDUCTION_MODE, 8'hFF, 16'h0043);
      cm[0] = 16'h0043;
      cm[1] = 16'h0043;
      // running: refusals, range bit kept, ramps
      run = 2'h3;
      on = 2'h3;
      cyc(4);
      check_all();
      wrc(DCC_CMD_SWITCHING_RATE, 8'h00, 16'($urandom));
      chk(bsy, 1'b1);
      cyc(1);
      check_all();
      wrc(DCC_CMD_PHASE_COUPLING, 8'h00, 16'h0005);
      chk(bsy, 1'b1);
      cyc(1);
      check_all();
      wrc(DCC_CMD_CONDUCTION_MODE, 8'h00, 16'h0040);
      cm[0] = 16'h0042;
      // range refusal passes the channel flop, busy one cycle later
      cyc(1);
      chk(bsy, 1'b1);
      check_all();
      rup = 2'h1;
      rdn = 2'h2;
      cyc(1);
      check_all();
      rup = 2'h0;
      rdn = 2'h0;
      on = 2'h2;
      cyc(1);
      check_all();
      chk(bsy_flag, 1'b1);
      // soft reset restores defaults and clears busy
      wrc(DCC_CMD_SOFT_RESET, 8'h00, 16'h0000);
      chk(srst, 1'b1);
      cm[0] = 16'h00C1;
      cm[1] = 16'h00C1;
      pc = 16'h0010;
      rate = 16'hFABC;
      cyc(1);
      chk(bsy_flag, 1'b0);
      check_all();
      wrc(DCC_CMD_SWITCHING_RATE, 8'h00, 16'h03E8);
      chk(bsy, 1'b1);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      chk(bsy_flag, 1'b0);
      wrc(8'h99, 8'h00, 16'h0000);
      chk(cml, 1'b1);
      // off again: rate write taken
      run = 2'h0;
      on = 2'h0;
      cyc(3);
      d = 16'($urandom);
      wrc(DCC_CMD_SWITCHING_RATE, 8'h00, d);
      rate = d;
      cyc(1);
      check_all();
      rdc(DCC_CMD_SWITCHING_RATE, 8'h00, rate);
      // share clock against input thresholds
      chk(sc_oe_n, 1'b0);
      chk(sc_out, 1'b0);
      input_turn_on_threshold = 1'b1;
      cyc(8);
      chk(sc_oe_n, 1'b1);
      chk(sc_lvl, 1'b1);
      input_turn_on_threshold = 1'b0;
      input_turn_off_threshold = 1'b1;
      cyc(8);
      chk(sc_oe_n, 1'b0);
      chk(sc_lvl, 1'b0);
      input_turn_off_threshold = 1'b0;
      input_turn_on_threshold = 1'b1;
      cyc(5);
      wrc(DCC_CMD_PHASE_COUPLING, 8'h00, 16'h0000);
      pc = 16'h0000;
      cyc(1);
      check_all();
      // unsupported phase code is refused and ignored
      wrc(DCC_CMD_PHASE_COUPLING, 8'h00, 16'h0007);
      chk(cml, 1'b1);
      cyc(1);
      check_all();
      input_turn_on_threshold = 1'b0;
      input_turn_off_threshold = 1'b1;
      cyc(5);
      chk(sc_oe_n, 1'b1);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
